/* hw/mcrs_core_regs.sv */
// Purpose: programmer-visible core registers, working banks and fetch address
// Assumes: one core clock; core drives one direct-address access per cycle
// Notes: software writes take priority over a result written in the same cycle, except the parity flag, which always follows the work value
`include "mcrs_defs.svh"

module mcrs_core_regs #(
	parameter int BANK_COUNT = 4,
	parameter int BANK_DEPTH = 8
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	input wire logic [7:0] bitAddr,
	input wire logic bitWrEn,
	input wire logic bitWrVal,
	input wire logic bitRdEn,
	output logic bitRdVal,
	input wire mcrs_pkg::mcrs_alu_op_type aluOp,
	input wire logic aluWorkWrEn,
	input wire logic [7:0] aluWork,
	input wire logic aluMathWrEn,
	input wire logic [7:0] aluMath,
	input wire logic aluCarry,
	input wire logic aluHalfCarry,
	input wire logic aluWrap,
	input wire logic [2:0] bankIdx,
	input wire logic bankWrEn,
	input wire logic [7:0] bankWrData,
	input wire logic bankRdEn,
	output logic [7:0] bankRdData,
	input wire logic [4:0] ramAddr,
	input wire logic ramWrEn,
	input wire logic [7:0] ramWrData,
	input wire logic ramRdEn,
	output logic [7:0] ramRdData,
	input wire logic pushEn,
	input wire logic popEn,
	output logic [7:0] stackAddr,
	output logic stackWrStrobe,
	output logic stackRdStrobe,
	input wire logic instrDone,
	input wire logic [1:0] instrLen,
	input wire logic jumpEn,
	input wire logic [15:0] jumpAddr,
	input wire logic opcodeLoad,
	input wire logic [7:0] opcodeIn,
	output logic [7:0] opcodeHolder,
	output logic [15:0] nextFetchAddress,
	output logic [15:0] dataPointer,
	output logic [7:0] workRegister,
	output logic [7:0] mathOperand,
	output logic [7:0] processorFlags,
	output logic [7:0] stackPointer,
	output logic baudDouble,
	output logic uartCheckEnable,
	output logic syncPortChoice,
	output logic carrier38kEnable,
	output logic xdataRamEnable
);
	localparam int RAM_DEPTH = BANK_COUNT * BANK_DEPTH;

	logic [7:0] work_r, work_nxt;
	logic [7:0] math_r, math_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [7:0] stack_r, stack_nxt;
	logic [7:0] ptrLow_r, ptrHigh_r;
	logic [7:0] power_r, config_r;
	logic xdata_r;
	logic [15:0] fetch_r;
	logic [7:0] opcode_r;
	logic [7:0] ram_r [RAM_DEPTH];
	logic [4:0] bankAddr;
	logic [7:0] bitBase;
	logic [2:0] bitPos;
	logic [7:0] rdMux;
	logic wrWork, wrMath, wrFlags;
	logic bitWork, bitMath, bitFlags;
	logic arithOp;

	assign bitBase = bitAddr & `MCRS_BIT_BASE_MASK;
	assign bitPos = bitAddr[2:0];
	// only these three bytes answer in bit space
	assign bitWork = bitWrEn && (bitBase == `MCRS_OFS_WORK);
	assign bitMath = bitWrEn && (bitBase == `MCRS_OFS_MATH);
	assign bitFlags = bitWrEn && (bitBase == `MCRS_OFS_FLAGS);
	assign wrWork = sfrWrEn && (sfrAddr == `MCRS_OFS_WORK);
	assign wrMath = sfrWrEn && (sfrAddr == `MCRS_OFS_MATH);
	assign wrFlags = sfrWrEn && (sfrAddr == `MCRS_OFS_FLAGS);
	assign arithOp = (aluOp == mcrs_pkg::ALU_ADD) || (aluOp == mcrs_pkg::ALU_ADDC)
		|| (aluOp == mcrs_pkg::ALU_SUBB) || (aluOp == mcrs_pkg::ALU_MUL)
		|| (aluOp == mcrs_pkg::ALU_DIV);
	// active bank from flag bits 4-3 forms the upper RAM address bits
	assign bankAddr = {flags_r[`MCRS_FLAG_BANK_HI:`MCRS_FLAG_BANK_LO], bankIdx};

	always_comb
	begin
		work_nxt = work_r;
		if (aluWorkWrEn)
			work_nxt = aluWork;
		if (wrWork)
			work_nxt = sfrWrData;
		if (bitWork)
			work_nxt[bitPos] = bitWrVal;
	end

	always_comb
	begin
		math_nxt = math_r;
		if (aluMathWrEn)
			math_nxt = aluMath;
		if (wrMath)
			math_nxt = sfrWrData;
		if (bitMath)
			math_nxt[bitPos] = bitWrVal;
	end

	always_comb
	begin
		flags_nxt = flags_r;
		case (aluOp)
			mcrs_pkg::ALU_ADD, mcrs_pkg::ALU_ADDC:
			begin
				flags_nxt[`MCRS_FLAG_CARRY] = aluCarry;
				flags_nxt[`MCRS_FLAG_HALF_CARRY] = aluHalfCarry;
				flags_nxt[`MCRS_FLAG_WRAP] = aluWrap;
			end
			mcrs_pkg::ALU_SUBB, mcrs_pkg::ALU_MUL, mcrs_pkg::ALU_DIV:
			begin
				flags_nxt[`MCRS_FLAG_CARRY] = aluCarry;
				flags_nxt[`MCRS_FLAG_WRAP] = aluWrap;
			end
			default:
			begin
				flags_nxt = flags_r;
			end
		endcase
		// user flags change only here, never from a result
		if (wrFlags)
			flags_nxt = sfrWrData;
		if (bitFlags)
			flags_nxt[bitPos] = bitWrVal;
		// parity tracks the next work value, so it is never a cycle stale
		flags_nxt[`MCRS_FLAG_PARITY] = ^work_nxt;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			work_r <= `MCRS_RST_WORK;
			math_r <= `MCRS_RST_MATH;
			flags_r <= `MCRS_RST_FLAGS;
		end
		else
		begin
			work_r <= work_nxt;
			math_r <= math_nxt;
			flags_r <= flags_nxt;
		end
	end

	// byte-only registers; reserved bits are stored as written
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ptrLow_r <= `MCRS_RST_POINTER;
			ptrHigh_r <= `MCRS_RST_POINTER;
			power_r <= `MCRS_RST_POWER_CONTROL;
			config_r <= `MCRS_RST_CONFIG;
			xdata_r <= 1'b0;
		end
		else if (sfrWrEn)
		begin
			if (sfrAddr == `MCRS_OFS_POINTER_LOW)
				ptrLow_r <= sfrWrData;
			if (sfrAddr == `MCRS_OFS_POINTER_HIGH)
				ptrHigh_r <= sfrWrData;
			if (sfrAddr == `MCRS_OFS_POWER_CONTROL)
				power_r <= sfrWrData;
			if (sfrAddr == `MCRS_OFS_CONFIG)
				config_r <= sfrWrData;
			// enable kept in its own flop so the output carries no gate
			if (sfrAddr == `MCRS_OFS_CONFIG)
				xdata_r <= sfrWrData[`MCRS_CFG_XDATA_HI] | sfrWrData[`MCRS_CFG_XDATA_LO];
		end
	end

	// push bumps first, pop uses the current top; a software write wins
	always_comb
	begin
		stack_nxt = stack_r;
		if (pushEn)
			stack_nxt = stack_r + 8'h01;
		else if (popEn)
			stack_nxt = stack_r - 8'h01;
		if (sfrWrEn && (sfrAddr == `MCRS_OFS_STACK_POINTER))
			stack_nxt = sfrWrData;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stack_r <= `MCRS_RST_STACK_POINTER;
			stackAddr <= `MCRS_RST_STACK_POINTER;
			stackWrStrobe <= 1'b0;
			stackRdStrobe <= 1'b0;
		end
		else
		begin
			stack_r <= stack_nxt;
			stackWrStrobe <= pushEn;
			stackRdStrobe <= popEn && !pushEn;
			if (pushEn)
				stackAddr <= stack_r + 8'h01;
			else if (popEn)
				stackAddr <= stack_r;
		end
	end

	// no software path reaches the fetch address or the opcode
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			fetch_r <= `MCRS_RST_FETCH;
		else if (jumpEn)
			fetch_r <= jumpAddr;
		else if (instrDone)
			fetch_r <= fetch_r + {14'h0000, instrLen};
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			opcode_r <= `MCRS_RST_OPCODE;
		else if (opcodeLoad)
			opcode_r <= opcodeIn;
	end

	// bank port wins over the direct RAM port when both write
	always_ff @(posedge ref_clk)
	begin
		if (bankWrEn)
			ram_r[bankAddr] <= bankWrData;
		else if (ramWrEn)
			ram_r[ramAddr] <= ramWrData;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bankRdData <= 8'h00;
			ramRdData <= 8'h00;
		end
		else
		begin
			if (bankRdEn)
				bankRdData <= ram_r[bankAddr];
			if (ramRdEn)
				ramRdData <= ram_r[ramAddr];
		end
	end

	always_comb
	begin
		case (sfrAddr)
			`MCRS_OFS_STACK_POINTER: rdMux = stack_r;
			`MCRS_OFS_POINTER_LOW: rdMux = ptrLow_r;
			`MCRS_OFS_POINTER_HIGH: rdMux = ptrHigh_r;
			`MCRS_OFS_POWER_CONTROL: rdMux = power_r;
			`MCRS_OFS_CONFIG: rdMux = config_r;
			`MCRS_OFS_FLAGS: rdMux = flags_r;
			`MCRS_OFS_WORK: rdMux = work_r;
			`MCRS_OFS_MATH: rdMux = math_r;
			default: rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sfrRdData <= 8'h00;
			bitRdVal <= 1'b0;
		end
		else
		begin
			if (sfrRdEn)
				sfrRdData <= rdMux;
			if (bitRdEn)
			begin
				case (bitAddr & `MCRS_BIT_BASE_MASK)
					`MCRS_OFS_WORK: bitRdVal <= work_r[bitAddr[2:0]];
					`MCRS_OFS_MATH: bitRdVal <= math_r[bitAddr[2:0]];
					`MCRS_OFS_FLAGS: bitRdVal <= flags_r[bitAddr[2:0]];
					default: bitRdVal <= 1'b0;
				endcase
			end
		end
	end

	assign workRegister = work_r;
	assign mathOperand = math_r;
	assign processorFlags = flags_r;
	assign stackPointer = stack_r;
	assign dataPointer = {ptrHigh_r, ptrLow_r};
	assign nextFetchAddress = fetch_r;
	assign opcodeHolder = opcode_r;
	assign baudDouble = power_r[`MCRS_PWR_BAUD_DOUBLE];
	assign uartCheckEnable = config_r[`MCRS_CFG_UART_CHECK];
	assign syncPortChoice = config_r[`MCRS_CFG_SYNC_PORT];
	assign carrier38kEnable = config_r[`MCRS_CFG_CARRIER_38K];
	assign xdataRamEnable = xdata_r;

	chk_parity_even: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(^{work_r, flags_r[`MCRS_FLAG_PARITY]}) == 1'b0)
		else $error("parity bit does not make work register parity even");

	chk_carry_result: assert property (@(posedge ref_clk) disable iff (!reset_n)
		arithOp && !wrFlags && !bitFlags |=> flags_r[`MCRS_FLAG_CARRY] == $past(aluCarry))
		else $error("carry not taken from arithmetic result");

	chk_half_carry_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(aluOp != mcrs_pkg::ALU_ADD) && (aluOp != mcrs_pkg::ALU_ADDC) && !wrFlags && !bitFlags
		|=> $stable(flags_r[`MCRS_FLAG_HALF_CARRY]))
		else $error("half carry changed by an operation other than add");

	chk_wrap_result: assert property (@(posedge ref_clk) disable iff (!reset_n)
		arithOp && !wrFlags && !bitFlags |=> flags_r[`MCRS_FLAG_WRAP] == $past(aluWrap))
		else $error("overflow not taken from arithmetic result");

	chk_user_flags_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!wrFlags && !bitFlags |=> $stable({flags_r[`MCRS_FLAG_USER_ZERO],
		flags_r[`MCRS_FLAG_USER_ONE]}))
		else $error("user flag changed without a software write");

	chk_push_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pushEn && !(sfrWrEn && sfrAddr == `MCRS_OFS_STACK_POINTER)
		|=> stackWrStrobe && stackAddr == stack_r && stack_r == $past(stack_r) + 8'h01)
		else $error("push did not write at the incremented pointer");

	chk_pop_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
		popEn && !pushEn && !(sfrWrEn && sfrAddr == `MCRS_OFS_STACK_POINTER)
		|=> stackRdStrobe && stackAddr == $past(stack_r) && stack_r == $past(stack_r) - 8'h01)
		else $error("pop did not read the top before decrementing");

	chk_fetch_advance: assert property (@(posedge ref_clk) disable iff (!reset_n)
		instrDone && !jumpEn |=> fetch_r == $past(fetch_r) + {14'h0000, $past(instrLen)})
		else $error("fetch address did not advance by instruction length");

	chk_fetch_jump: assert property (@(posedge ref_clk) disable iff (!reset_n)
		jumpEn ##1 !jumpEn && !instrDone |=> fetch_r == $past(jumpAddr, 2))
		else $error("fetch address lost a jump target");

	chk_pointer_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sfrWrEn && sfrAddr == `MCRS_OFS_POINTER_LOW
		|=> dataPointer[7:0] == $past(sfrWrData) && $stable(dataPointer[15:8]))
		else $error("low pointer write disturbed or missed");

	chk_xdata_enable: assert property (@(posedge ref_clk) disable iff (!reset_n)
		xdataRamEnable == (config_r[`MCRS_CFG_XDATA_HI:`MCRS_CFG_XDATA_LO] != 2'b00))
		else $error("extended RAM enable does not follow its field");

	cov_push_pop: cover property (@(posedge ref_clk) disable iff (!reset_n)
		pushEn ##1 popEn);
	cov_jump: cover property (@(posedge ref_clk) disable iff (!reset_n) jumpEn);
	cov_flag_bit_write: cover property (@(posedge ref_clk) disable iff (!reset_n)
		bitFlags && bitPos == 3'h4);
	cov_bank_access: cover property (@(posedge ref_clk) disable iff (!reset_n)
		bankWrEn ##1 bankRdEn);
endmodule

/* hw/mcrs_defs.svh */
// Purpose: address, bit position and reset constants of the core register set
// Assumes: 8-bit direct address space shared with the core
// Notes: bit addresses of a bit-addressable byte are its base plus the bit number
`ifndef MCRS_DEFS_SVH
`define MCRS_DEFS_SVH

`define MCRS_OFS_STACK_POINTER 8'h81
`define MCRS_OFS_POINTER_LOW 8'h82
`define MCRS_OFS_POINTER_HIGH 8'h83
`define MCRS_OFS_POWER_CONTROL 8'h87
`define MCRS_OFS_CONFIG 8'haf
`define MCRS_OFS_FLAGS 8'hd0
`define MCRS_OFS_WORK 8'he0
`define MCRS_OFS_MATH 8'hf0
`define MCRS_BIT_BASE_MASK 8'hf8

`define MCRS_RST_STACK_POINTER 8'h07
`define MCRS_RST_POINTER 8'h00
`define MCRS_RST_POWER_CONTROL 8'h00
`define MCRS_RST_CONFIG 8'h80
`define MCRS_RST_FLAGS 8'h00
`define MCRS_RST_WORK 8'h00
`define MCRS_RST_MATH 8'h00
`define MCRS_RST_FETCH 16'h0000
`define MCRS_RST_OPCODE 8'h00

`define MCRS_FLAG_CARRY 7
`define MCRS_FLAG_HALF_CARRY 6
`define MCRS_FLAG_USER_ZERO 5
`define MCRS_FLAG_BANK_HI 4
`define MCRS_FLAG_BANK_LO 3
`define MCRS_FLAG_WRAP 2
`define MCRS_FLAG_USER_ONE 1
`define MCRS_FLAG_PARITY 0

`define MCRS_PWR_BAUD_DOUBLE 7
`define MCRS_CFG_UART_CHECK 6
`define MCRS_CFG_SYNC_PORT 5
`define MCRS_CFG_CARRIER_38K 4
`define MCRS_CFG_XDATA_HI 1
`define MCRS_CFG_XDATA_LO 0

`endif

/* hw/mcrs_pkg.sv */
// Purpose: shared types of the core register set
// Assumes: used with mcrs_defs.svh
// Notes: operation codes are driven by the instruction decoder
package mcrs_pkg;
	typedef enum logic [2:0] {
		ALU_NONE = 3'h0,
		ALU_ADD = 3'h1,
		ALU_ADDC = 3'h2,
		ALU_SUBB = 3'h3,
		ALU_MUL = 3'h4,
		ALU_DIV = 3'h5,
		ALU_LOGIC = 3'h6
	} mcrs_alu_op_type;
	typedef logic [7:0] mcrs_byte_type;
endpackage

/* dv/mcrs_core_regs_tb_top.sv */
// Purpose: self-checking bench for the core register set
// Assumes: inputs change 1 ns after the rising edge, results sampled there
// Notes: shadow copies of work, math, flag, stack pointer and fetch address bytes feed the expectations
module mcrs_core_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] sfrAddr, sfrWrData, bitAddr, aluWork, aluMath, bankWrData, ramWrData, opcodeIn;
	logic sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, bitRdEn, aluWorkWrEn, aluMathWrEn;
	logic aluCarry, aluHalfCarry, aluWrap, bankWrEn, bankRdEn, ramWrEn, ramRdEn;
	logic pushEn, popEn, instrDone, jumpEn, opcodeLoad;
	logic [2:0] bankIdx;
	logic [4:0] ramAddr;
	logic [1:0] instrLen;
	logic [15:0] jumpAddr;
	mcrs_pkg::mcrs_alu_op_type aluOp;
	logic [7:0] sfrRdData, bankRdData, ramRdData, stackAddr, opcodeHolder, workRegister;
	logic [7:0] mathOperand, processorFlags, stackPointer;
	logic bitRdVal, stackWrStrobe, stackRdStrobe, baudDouble, uartCheckEnable;
	logic syncPortChoice, carrier38kEnable, xdataRamEnable;
	logic [15:0] nextFetchAddress, dataPointer;
	int err_total = 0;
	int total_checks = 0;
	int seed = 32'h38d7;
	logic [7:0] wk, mth, fl, sp, d, rd, m;
	logic [15:0] pc;
	logic c, h, v;
	logic [7:0] regAddr [8] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'haf, 8'hd0, 8'he0, 8'hf0};
	logic [7:0] regRst [8] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
	logic [7:0] bitBase [3] = '{8'he0, 8'hf0, 8'hd0};

	mcrs_core_regs u_mcrs_core_regs (.ref_clk, .reset_n, .sfrAddr, .sfrWrEn, .sfrWrData,
		.sfrRdEn, .sfrRdData, .bitAddr, .bitWrEn, .bitWrVal, .bitRdEn, .bitRdVal, .aluOp,
		.aluWorkWrEn, .aluWork, .aluMathWrEn, .aluMath, .aluCarry, .aluHalfCarry, .aluWrap,
		.bankIdx, .bankWrEn, .bankWrData, .bankRdEn, .bankRdData, .ramAddr, .ramWrEn,
		.ramWrData, .ramRdEn, .ramRdData, .pushEn, .popEn, .stackAddr, .stackWrStrobe,
		.stackRdStrobe, .instrDone, .instrLen, .jumpEn, .jumpAddr, .opcodeLoad, .opcodeIn,
		.opcodeHolder, .nextFetchAddress, .dataPointer, .workRegister, .mathOperand,
		.processorFlags, .stackPointer, .baudDouble, .uartCheckEnable, .syncPortChoice,
		.carrier38kEnable, .xdataRamEnable);

	always #2 ref_clk = ~ref_clk;

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] dv);
		sfrAddr = a;
		sfrWrData = dv;
		sfrWrEn = 1'b1;
		tick();
		sfrWrEn = 1'b0;
	endtask

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] q);
		sfrAddr = a;
		sfrRdEn = 1'b1;
		tick();
		sfrRdEn = 1'b0;
		q = sfrRdData;
	endtask

	task automatic bit_wr(input logic [7:0] a, input logic bv);
		bitAddr = a;
		bitWrVal = bv;
		bitWrEn = 1'b1;
		tick();
		bitWrEn = 1'b0;
		bitRdEn = 1'b1;
		tick();
		bitRdEn = 1'b0;
	endtask

	// one push or pop; the pointer wraps through 8 bits
	task automatic stk(input logic p);
		logic [7:0] old;
		old = sp;
		pushEn = p;
		popEn = !p;
		tick();
		pushEn = 1'b0;
		popEn = 1'b0;
		sp = p ? old + 8'h01 : old - 8'h01;
		check(stackAddr, p ? sp : old);
		check({stackWrStrobe, stackRdStrobe}, {p, !p});
		check(stackPointer, sp);
	endtask

	function automatic logic [7:0] alu_flags(input int op, input logic [7:0] f,
		input logic cy, input logic hc, input logic ov, input logic [7:0] w);
		logic [7:0] r;
		r = f;
		if (op >= 1 && op <= 5)
		begin
			r[7] = cy;
			r[2] = ov;
		end
		if (op == 1 || op == 2)
			r[6] = hc;
		r[0] = ^w;
		return r;
	endfunction

	initial
	begin
		{sfrAddr, sfrWrData, bitAddr, aluWork, aluMath, bankWrData, ramWrData, opcodeIn} = '0;
		{sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, bitRdEn, aluWorkWrEn, aluMathWrEn} = '0;
		{aluCarry, aluHalfCarry, aluWrap, bankWrEn, bankRdEn, ramWrEn, ramRdEn} = '0;
		{pushEn, popEn, instrDone, jumpEn, opcodeLoad, bankIdx, ramAddr, instrLen} = '0;
		jumpAddr = '0;
		aluOp = mcrs_pkg::ALU_NONE;
		repeat (3) @(posedge ref_clk);
		#1 reset_n = 1'b1;
		check(nextFetchAddress, 16'h0000);
		foreach (regAddr[i])
		begin
			sfr_rd(regAddr[i], rd);
			check(rd, regRst[i]);
		end
		wk = 8'h00;
		mth = 8'h00;
		fl = 8'h00;
		for (int n = 0; n < 4; n++)
			foreach (regAddr[i])
			begin
				d = $random(seed);
				if (i == 3)
					d[6:0] = 7'h00;
				if (i == 4)
					d[7] = 1'b1;
				if (i == 5)
					d[0] = 1'b0;
				if (i == 6)
					wk = d;
				sfr_wr(regAddr[i], d);
				if (i == 5)
					fl = {d[7:1], ^wk};
				case (i)
				0: check(stackPointer, d);
				1: check(dataPointer[7:0], d);
				2: check(dataPointer[15:8], d);
				3: check(baudDouble, d[7]);
				4: check({uartCheckEnable, syncPortChoice, carrier38kEnable}, d[6:4]);
				5: check(processorFlags, fl);
				6: check(processorFlags[0], ^d);
				default: check(mathOperand, d);
				endcase
				sfr_rd(regAddr[i], rd);
				check(rd, i == 5 ? fl : d);
			end
		mth = d;
		for (int k = 0; k < 4; k++)
		begin
			sfr_wr(8'haf, 8'h80 | k[7:0]);
			check(xdataRamEnable, k != 0);
		end
		sfr_wr(8'h90, 8'h5a);
		sfr_rd(8'h90, rd);
		check(rd, 8'h00);
		sfr_wr(8'h87, 8'h00);
		bit_wr(8'h87, 1'b1);
		check({bitRdVal, baudDouble}, 2'b00);
		foreach (bitBase[j])
			for (int k = 1; k < 8; k++)
			begin
				v = $random(seed);
				bit_wr(bitBase[j] | k[7:0], v);
				check(bitRdVal, v);
				if (j == 0)
					wk[k] = v;
				if (j == 1)
					mth[k] = v;
				if (j == 2)
					fl[k] = v;
				fl[0] = ^wk;
				check({workRegister, mathOperand}, {wk, mth});
				check(processorFlags, fl);
			end
		check(nextFetchAddress, 16'h0000);
		for (int n = 0; n < 14; n++)
		begin
			{c, h, v} = $random(seed);
			d = $random(seed);
			m = $random(seed);
			aluOp = mcrs_pkg::mcrs_alu_op_type'(n % 7);
			{aluCarry, aluHalfCarry, aluWrap, aluWork, aluMath} = {c, h, v, d, m};
			{aluWorkWrEn, aluMathWrEn} = 2'b11;
			tick();
			{aluWorkWrEn, aluMathWrEn} = 2'b00;
			aluOp = mcrs_pkg::ALU_NONE;
			fl = alu_flags(n % 7, fl, c, h, v, d);
			check(processorFlags, fl);
			check({workRegister, mathOperand}, {d, m});
		end
		// software write and result write in one cycle: software wins
		aluWork = 8'h0f;
		aluWorkWrEn = 1'b1;
		sfr_wr(8'he0, 8'h01);
		aluWorkWrEn = 1'b0;
		wk = 8'h01;
		check({workRegister, processorFlags[0]}, {8'h01, 1'b1});
		fl[0] = 1'b1;
		for (int b = 0; b < 4; b++)
		begin
			fl[4:3] = b[1:0];
			sfr_wr(8'hd0, fl);
			bankIdx = $random(seed);
			bankWrData = $random(seed);
			bankWrEn = 1'b1;
			tick();
			bankWrEn = 1'b0;
			ramAddr = {b[1:0], bankIdx};
			ramRdEn = 1'b1;
			bankRdEn = 1'b1;
			tick();
			{ramRdEn, bankRdEn} = 2'b00;
			check(ramRdData, bankWrData);
			check(bankRdData, bankWrData);
		end
		sp = 8'hfe;
		sfr_wr(8'h81, sp);
		stk(1'b1);
		stk(1'b1);
		stk(1'b0);
		stk(1'b0);
		tick();
		check({stackWrStrobe, stackRdStrobe}, 2'b00);
		jumpAddr = 16'hfffe;
		{jumpEn, instrDone} = 2'b11;
		tick();
		{jumpEn, instrDone} = 2'b00;
		check(nextFetchAddress, 16'hfffe);
		tick();
		check(nextFetchAddress, 16'hfffe);
		pc = 16'hfffe;
		for (int k = 0; k < 6; k++)
		begin
			instrLen = 2'(1 + k % 3);
			instrDone = 1'b1;
			opcodeIn = $random(seed);
			opcodeLoad = 1'b1;
			tick();
			{instrDone, opcodeLoad} = 2'b00;
			pc = pc + instrLen;
			check(nextFetchAddress, pc);
			check(opcodeHolder, opcodeIn);
		end
		report_and_stop();
	end

	initial
	begin
		#40000;
		err_total++;
		report_and_stop();
	end
endmodule
